// ---- gpib_map.vh ----
// gpib_map.vh: constants for the ieee-488 bus handshake block
// assumes a 100 MHz clock
`ifndef GPIB_MAP_VH
`define GPIB_MAP_VH
// =============================================================
// timing
`define IFC_MIN_US         100
`define IFC_CYCLES         ((`IFC_MIN_US * 1000 + 10 - 1) / 10)
`define SETTLE_CYCLES      4'h2
// =============================================================
// source handshake states
`define SH_IDLE            3'h0
`define SH_SETTLE          3'h1
`define SH_WAIT_RFD        3'h2
`define SH_DAV             3'h3
`define SH_WAIT_DAC        3'h4
// =============================================================
// acceptor handshake states
`define AH_IDLE            2'h0
`define AH_READY           2'h1
`define AH_TAKEN           2'h2
`define AH_WAIT_END        2'h3
// =============================================================
// controller states
`define CT_IDLE            2'h0
`define CT_ACTIVE          2'h1
`define CT_STANDBY         2'h2
`endif

// ---- src_handshake.v ----
// src_handshake.v: three-wire source handshake for one byte at a time
// assumes true-high bus levels from the caller
`include "gpib_map.vh"
module src_handshake (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       enable,
    input  wire       start,
    input  wire       nrfd_true,
    input  wire       ndac_true,
    output reg        dav_true,
    output wire       busy,
    output reg        done
);
    reg [2:0] state_q;
    reg [3:0] settle_q;

    assign busy = (state_q != `SH_IDLE);

    // =============================================================
    // source sequence
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q  <= `SH_IDLE;
            settle_q <= 4'h0;
            dav_true <= 1'b0;
            done     <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (!enable) begin
                state_q  <= `SH_IDLE;
                dav_true <= 1'b0;
            end else begin
                case (state_q)
                    `SH_IDLE: begin
                        if (start) begin
                            state_q  <= `SH_SETTLE;
                            settle_q <= 4'h0;
                        end
                    end
                    `SH_SETTLE: begin
                        // data lines settle before dav may rise
                        settle_q <= settle_q + 4'h1;
                        if (settle_q == `SETTLE_CYCLES)
                            state_q <= `SH_WAIT_RFD;
                    end
                    `SH_WAIT_RFD: begin
                        if (!nrfd_true) begin
                            dav_true <= 1'b1;
                            state_q  <= `SH_DAV;
                        end
                    end
                    `SH_DAV: begin
                        state_q <= `SH_WAIT_DAC;
                    end
                    `SH_WAIT_DAC: begin
                        if (!ndac_true) begin
                            dav_true <= 1'b0;
                            done     <= 1'b1;
                            state_q  <= `SH_IDLE;
                        end
                    end
                    default: state_q <= `SH_IDLE;
                endcase
            end
        end
    end
endmodule // src_handshake

// ---- acc_handshake.v ----
// acc_handshake.v: acceptor handshake, drives nrfd and ndac
// assumes true-high bus levels from the caller
`include "gpib_map.vh"
module acc_handshake (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       enable,
    input  wire       can_take,
    input  wire       dav_true,
    input  wire [7:0] dio_true,
    input  wire       atn_true,
    input  wire       eoi_true,
    output reg        nrfd_true,
    output reg        ndac_true,
    output reg  [7:0] byte_q,
    output reg        byte_is_cmd,
    output reg        byte_end,
    output reg        byte_stb
);
    reg [1:0] state_q;

    // =============================================================
    // acceptor sequence
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q     <= `AH_IDLE;
            nrfd_true   <= 1'b0;
            ndac_true   <= 1'b0;
            byte_q      <= 8'h00;
            byte_is_cmd <= 1'b0;
            byte_end    <= 1'b0;
            byte_stb    <= 1'b0;
        end else if (ce) begin
            byte_stb <= 1'b0;
            if (!enable) begin
                state_q   <= `AH_IDLE;
                nrfd_true <= 1'b0;
                ndac_true <= 1'b0;
            end else begin
                case (state_q)
                    `AH_IDLE: begin
                        ndac_true <= 1'b1;
                        nrfd_true <= !can_take;
                        if (can_take && !dav_true)
                            state_q <= `AH_READY;
                    end
                    `AH_READY: begin
                        nrfd_true <= 1'b0;
                        ndac_true <= 1'b1;
                        if (dav_true) begin
                            nrfd_true   <= 1'b1;
                            byte_q      <= dio_true;
                            byte_is_cmd <= atn_true;
                            byte_end    <= eoi_true && !atn_true;
                            byte_stb    <= 1'b1;
                            state_q     <= `AH_TAKEN;
                        end
                    end
                    `AH_TAKEN: begin
                        ndac_true <= 1'b0;
                        state_q   <= `AH_WAIT_END;
                    end
                    `AH_WAIT_END: begin
                        if (!dav_true) begin
                            ndac_true <= 1'b1;
                            state_q   <= `AH_IDLE;
                        end
                    end
                    default: state_q <= `AH_IDLE;
                endcase
            end
        end
    end
endmodule // acc_handshake

// ---- gpib_bus_ctrl.v ----
// gpib_bus_ctrl.v: ieee-488 talker, listener and controller bus side
// assumes inputs synchronous to clk; open-drain pin triples
`include "gpib_map.vh"
// Contract
// - pio or dma both move bytes
// - byte under atn is command
// - one talker, many listeners
// - talker sources, listeners accept bytes
// - cic active with atn, else standby
// - only sys controller drives ifc, ren
// - bus lines are negative logic
// - eight data, three handshake, five management
// - nrfd released under atn by all; here a device holding an unread byte keeps nrfd true
// - nrfd true if any listener unready
// - dav driven by controller or talker
// - ndac released once byte taken
// - cic holds atn sending commands
// - system controller holds ifc 100 us
// - ren false returns device to local
// - srq raised apart from handshake
// - eoi marks last talker byte
// - atn with eoi starts parallel poll
// - all four roles supported
// - only system controller takes charge itself
// - dma request output is active high
module gpib_bus_ctrl #(
    parameter IFC_CYCLES = `IFC_CYCLES
) (
    input  wire       clk,
    input  wire       rst,
    input  wire       ce,
    input  wire       module_init_in,
    // host byte port
    input  wire [7:0] command_data_out_reg,
    input  wire       out_wr,
    input  wire       out_last,
    output wire       out_ready,
    output reg  [7:0] data_in_reg_q,
    output reg        in_valid_q,
    output reg        in_is_cmd_q,
    output reg        in_end_q,
    input  wire       in_rd,
    // dma
    input  wire       dma_mode,
    output wire       dma_request_out,
    input  wire       dma_grant_in_n,
    // role control
    input  wire       listen_en,
    input  wire       talk_en,
    input  wire       sys_ctrl_en,
    input  wire       take_control,
    input  wire       go_standby,
    input  wire       pass_control,
    input  wire       send_ifc,
    input  wire       ren_set,
    input  wire       rsv,
    input  wire       par_poll,
    input  wire       pp_resp_en,
    input  wire [7:0] pp_resp,
    output reg        remote_q,
    output wire       cic,
    output wire       active_ctrl,
    output wire       ifc_busy,
    output wire       ifc_seen,
    output wire       srq_seen,
    // bus pins, low is true; oe_n low drives
    input  wire [7:0] dio_i,
    output wire [7:0] dio_o,
    output wire [7:0] dio_oe_n,
    input  wire       dav_i,
    output wire       dav_o,
    output wire       dav_oe_n,
    input  wire       nrfd_i,
    output wire       nrfd_o,
    output wire       nrfd_oe_n,
    input  wire       ndac_i,
    output wire       ndac_o,
    output wire       ndac_oe_n,
    input  wire       atn_i,
    output wire       atn_o,
    output wire       atn_oe_n,
    input  wire       ifc_i,
    output wire       ifc_o,
    output wire       ifc_oe_n,
    input  wire       ren_i,
    output wire       ren_o,
    output wire       ren_oe_n,
    input  wire       srq_i,
    output wire       srq_o,
    output wire       srq_oe_n,
    input  wire       eoi_i,
    output wire       eoi_o,
    output wire       eoi_oe_n
);
    // =============================================================
    // line polarity
    wire       srst = module_init_in;
    wire [7:0] dio_t  = ~dio_i;
    wire       dav_t  = ~dav_i;
    wire       nrfd_t = ~nrfd_i;
    wire       ndac_t = ~ndac_i;
    wire       atn_t  = ~atn_i;
    wire       ifc_t  = ~ifc_i;
    wire       ren_t  = ~ren_i;
    wire       srq_t  = ~srq_i;
    wire       eoi_t  = ~eoi_i;

    reg  [1:0] ctl_q;
    reg [15:0] ifc_cnt_q;
    reg        ifc_drv_q;
    reg        ren_drv_q;
    reg  [7:0] out_q;
    reg        out_full_q;
    reg        out_end_q;
    reg        out_cmd_q;
    reg        pp_q;

    assign cic         = (ctl_q != `CT_IDLE);
    assign active_ctrl = (ctl_q == `CT_ACTIVE);
    assign ifc_busy    = ifc_drv_q;
    assign ifc_seen    = ifc_t;
    assign srq_seen    = srq_t;

    // =============================================================
    // roles: talker sources only when not under atn
    wire talker   = talk_en && !active_ctrl && !atn_t;
    wire src_en   = (talker || active_ctrl) && !pp_q;
    wire lstn_all = atn_t && !active_ctrl;
    wire acc_en   = (listen_en && !atn_t) || lstn_all;

    wire src_dav;
    wire src_busy;
    wire src_done;
    wire acc_nrfd;
    wire acc_ndac;
    wire [7:0] acc_byte;
    wire acc_cmd;
    wire acc_end;
    wire acc_stb;
    wire src_start = out_full_q && !src_busy && (out_cmd_q == active_ctrl);

    src_handshake u_src (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .enable    (src_en),
        .start     (src_start),
        .nrfd_true (nrfd_t),
        .ndac_true (ndac_t),
        .dav_true  (src_dav),
        .busy      (src_busy),
        .done      (src_done)
    );

    acc_handshake u_acc (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .enable      (acc_en && !srst),
        .can_take    (!in_valid_q),
        .dav_true    (dav_t),
        .dio_true    (dio_t),
        .atn_true    (atn_t),
        .eoi_true    (eoi_t),
        .nrfd_true   (acc_nrfd),
        .ndac_true   (acc_ndac),
        .byte_q      (acc_byte),
        .byte_is_cmd (acc_cmd),
        .byte_end    (acc_end),
        .byte_stb    (acc_stb)
    );

    // =============================================================
    // byte registers, pio and dma share them
    wire dma_wr   = dma_mode && !dma_grant_in_n && !out_full_q && talk_en;
    wire dma_rd   = dma_mode && !dma_grant_in_n && in_valid_q && !talk_en;
    assign out_ready       = !out_full_q;
    assign dma_request_out = dma_mode && (talk_en ? !out_full_q : in_valid_q);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_q         <= 8'h00;
            out_full_q    <= 1'b0;
            out_end_q     <= 1'b0;
            out_cmd_q     <= 1'b0;
            data_in_reg_q <= 8'h00;
            in_valid_q    <= 1'b0;
            in_is_cmd_q   <= 1'b0;
            in_end_q      <= 1'b0;
        end else if (ce) begin
            if (srst || ifc_t) begin
                out_full_q <= 1'b0;
                in_valid_q <= 1'b0;
            end else begin
                if ((out_wr || dma_wr) && !out_full_q) begin
                    out_q      <= command_data_out_reg;
                    out_full_q <= 1'b1;
                    out_end_q  <= out_last;
                    out_cmd_q  <= active_ctrl;
                end else if (src_done) begin
                    out_full_q <= 1'b0;
                end
                if (acc_stb) begin
                    data_in_reg_q <= acc_byte;
                    in_is_cmd_q   <= acc_cmd;
                    in_end_q      <= acc_end;
                    in_valid_q    <= 1'b1;
                end else if (in_rd || dma_rd) begin
                    in_valid_q <= 1'b0;
                end
            end
        end
    end

    // =============================================================
    // controller states and system controller duties
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_q     <= `CT_IDLE;
            ifc_cnt_q <= 16'h0000;
            ifc_drv_q <= 1'b0;
            ren_drv_q <= 1'b0;
            remote_q  <= 1'b0;
            pp_q      <= 1'b0;
        end else if (ce) begin
            if (srst) begin
                ctl_q     <= `CT_IDLE;
                ifc_drv_q <= 1'b0;
                ren_drv_q <= 1'b0;
                remote_q  <= 1'b0;
                pp_q      <= 1'b0;
            end else begin
                ren_drv_q <= sys_ctrl_en && ren_set;
                if (!ren_t)
                    remote_q <= 1'b0;
                else if (ren_t && listen_en && atn_t)
                    remote_q <= 1'b1;
                if (sys_ctrl_en && send_ifc && !ifc_drv_q) begin
                    ifc_drv_q <= 1'b1;
                    ifc_cnt_q <= 16'h0000;
                end else if (ifc_drv_q) begin
                    ifc_cnt_q <= ifc_cnt_q + 16'h0001;
                    if (ifc_cnt_q == IFC_CYCLES[15:0] - 16'h0001)
                        ifc_drv_q <= 1'b0;
                end
                pp_q <= active_ctrl && par_poll && !src_busy;
                case (ctl_q)
                    `CT_IDLE: begin
                        if (ifc_drv_q || (sys_ctrl_en && take_control))
                            ctl_q <= `CT_ACTIVE;
                    end
                    `CT_ACTIVE: begin
                        if (pass_control && !src_busy)
                            ctl_q <= `CT_IDLE;
                        else if (go_standby && !src_busy)
                            ctl_q <= `CT_STANDBY;
                    end
                    `CT_STANDBY: begin
                        if (pass_control)
                            ctl_q <= `CT_IDLE;
                        else if (take_control)
                            ctl_q <= `CT_ACTIVE;
                    end
                    default: ctl_q <= `CT_IDLE;
                endcase
                if (ifc_t && !ifc_drv_q)
                    ctl_q <= `CT_IDLE;
            end
        end
    end

    // =============================================================
    // pin drive, open-drain: o is always low, oe_n low pulls true
    wire       pp_answer = lstn_all && eoi_t && pp_resp_en;
    wire [7:0] dio_drive = (src_en && src_busy) ? out_q :
                           (pp_answer ? pp_resp : 8'h00);
    assign dio_o     = 8'h00;
    assign dio_oe_n  = ~dio_drive;
    assign dav_o     = 1'b0;
    assign dav_oe_n  = ~src_dav;
    assign nrfd_o    = 1'b0;
    assign nrfd_oe_n = ~acc_nrfd;
    assign ndac_o    = 1'b0;
    assign ndac_oe_n = ~acc_ndac;
    assign atn_o     = 1'b0;
    assign atn_oe_n  = ~(active_ctrl);
    assign ifc_o     = 1'b0;
    assign ifc_oe_n  = ~(ifc_drv_q && sys_ctrl_en);
    assign ren_o     = 1'b0;
    assign ren_oe_n  = ~ren_drv_q;
    assign srq_o     = 1'b0;
    assign srq_oe_n  = ~(rsv && !cic);
    assign eoi_o     = 1'b0;
    assign eoi_oe_n  = ~((talker && src_busy && out_end_q) || pp_q);
endmodule // gpib_bus_ctrl

// ---- gpib_bus_ctrl_assertions.sv ----
// gpib_bus_ctrl_assertions.sv: port checks on gpib_bus_ctrl
// assumes one clock domain
// ==========================================================
// checker
module gpib_checks #(
    parameter int IFC_CYCLES = 20
) (
    input wire       clk, rst, send_ifc, sys_ctrl_en, ren_set, rsv, par_poll,
    input wire       dma_mode, talk_en, out_ready, in_valid_q, dma_request_out,
    input wire       cic, active_ctrl, ifc_oe_n, ren_oe_n, srq_oe_n, atn_oe_n,
    input wire       eoi_oe_n, dav_oe_n, nrfd_oe_n, ndac_oe_n, nrfd_i, ndac_i, dav_i,
    input wire [7:0] dio_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] ifc_len_q;
    always @(posedge clk or posedge rst) begin
        if (rst)
            ifc_len_q <= 16'h0000;
        else
            ifc_len_q <= ifc_oe_n ? 16'h0000 : ifc_len_q + 16'h0001;
    end
    a_ifc_hold_len: assert property ($rose(ifc_oe_n) |-> ifc_len_q == IFC_CYCLES)
        else $error("ifc length wrong");
    a_ifc_sys_only: assert property ($fell(ifc_oe_n) |->
        $past(sys_ctrl_en) && ($past(send_ifc) || $past(send_ifc, 2)))
        else $error("ifc not sys ctrl");
    a_ren_sys_only: assert property (!ren_oe_n |-> $past(sys_ctrl_en && ren_set))
        else $error("ren not sys ctrl");
    a_dav_after_rfd: assert property ($fell(dav_oe_n) |-> $past(nrfd_i) && $stable(dio_oe_n))
        else $error("dav before ready");
    a_dav_after_dac: assert property ($rose(dav_oe_n) |-> $past(ndac_i))
        else $error("dav dropped early");
    a_ndac_hold_rfd: assert property ($rose(ndac_oe_n) && !dav_i |-> !nrfd_oe_n)
        else $error("ndac early");
    a_ndac_rearm: assert property ($rose(dav_i) && ndac_oe_n && in_valid_q |-> ##[1:3] !ndac_oe_n)
        else $error("ndac not reasserted");
    a_idle_no_atn: assert property (!cic |-> atn_oe_n)
        else $error("atn driven while idle");
    a_atn_is_active: assert property (!atn_oe_n |-> active_ctrl && cic)
        else $error("atn not active");
    a_poll_identify: assert property (par_poll && active_ctrl |=> !eoi_oe_n && !atn_oe_n)
        else $error("identify not sent");
    a_srq_on_rsv: assert property (rsv && !cic ##1 rsv && !cic |-> !srq_oe_n)
        else $error("srq not driven");
    a_dma_request: assert property (dma_request_out ==
        (dma_mode && (talk_en ? out_ready : in_valid_q)))
        else $error("dma request wrong");
    c_ifc: cover property ($rose(ifc_oe_n));
    c_dav: cover property ($fell(dav_oe_n));
    c_ndac: cover property ($rose(ndac_oe_n) && in_valid_q);
endmodule // gpib_checks
bind gpib_bus_ctrl gpib_checks #(.IFC_CYCLES(IFC_CYCLES)) chk (.*);

// ---- far_instrument.sv ----
// far_instrument.sv: instrument on the far side of the bus
// assumes wired-and lines; an output high pulls its line low
// ==========================================================
// far side model
module far_instrument (
    input  wire        clk,
    input  wire        dav_w,
    input  wire        nrfd_w,
    input  wire        ndac_w,
    input  wire  [7:0] dio_w,
    input  wire        eoi_w,
    input  wire        listen,
    input  wire  [3:0] lag,
    output logic       nrfd_low = 1'b0,
    output logic       ndac_low = 1'b0,
    output logic       dav_low = 1'b0,
    output logic [7:0] dio_low = 8'h00,
    output logic       eoi_low = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_byte = 8'h00;
    logic       rx_end = 1'b0;
    task automatic step();
        @(posedge clk);
        #2;
    endtask
    always begin : acceptor
        step();
        nrfd_low = listen;
        ndac_low = listen;
        if (listen) begin
            repeat (lag) step();
            nrfd_low = 1'b0;
            while (dav_w && listen) step();
            if (listen) begin
                nrfd_low = 1'b1;
                rx_byte = ~dio_w;
                rx_end = ~eoi_w;
                repeat (lag) step();
                ndac_low = 1'b0;
                while (!dav_w && listen) step();
            end
        end
    end
    task automatic send(input logic [7:0] b, input logic last);
        dio_low = b;
        eoi_low = last;
        repeat (2) step();
        while (!nrfd_w) step();
        dav_low = 1'b1;
        while (!ndac_w) step();
        dav_low = 1'b0;
        dio_low = 8'h00;
        eoi_low = 1'b0;
        step();
    endtask
endmodule // far_instrument

// ---- ieee488_bus_handshake_control_test.sv ----
// ieee488_bus_handshake_control_test.sv: self-checking bench for gpib_bus_ctrl
// assumes the design, partner and checker files
// ==========================================================
// bench
module ieee488_bus_handshake_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, rst = 1, ce = 1, init = 0, out_wr = 0, out_last = 0, in_rd = 0;
    logic       dma_mode = 0, grant_n = 1, listen_en = 0, talk_en = 0, sys_ctrl_en = 0;
    logic       take_control = 0, go_standby = 0, pass_control = 0, send_ifc = 0;
    logic       ren_set = 0, rsv = 0, par_poll = 0, pp_resp_en = 0, peer_listen = 0;
    logic       x_atn = 0, x_eoi = 0, x_ren = 0, x_ifc = 0, x_srq = 0;
    logic [7:0] cdo = 8'h00, pp_resp = 8'h00;
    logic [3:0] peer_lag = 4'h0;
    int         n_errors = 0, checks_done = 0;
    wire        out_ready, in_valid, in_cmd, in_end, dma_req, remote, cic, active_ctrl;
    wire        ifc_seen, srq_seen, dav_oe_n, nrfd_oe_n, ndac_oe_n, atn_oe_n, ifc_oe_n;
    wire        ren_oe_n, srq_oe_n, eoi_oe_n, p_nrfd, p_ndac, p_dav, p_eoi;
    wire  [7:0] din, dio_oe_n, p_dio;
    wire        dav_w = dav_oe_n & ~p_dav;
    wire        nrfd_w = nrfd_oe_n & ~p_nrfd;
    wire        ndac_w = ndac_oe_n & ~p_ndac;
    wire        atn_w = atn_oe_n & ~x_atn;
    wire        eoi_w = eoi_oe_n & ~p_eoi & ~x_eoi;
    wire  [7:0] dio_w = dio_oe_n & ~p_dio;
    always #5 clk = ~clk;
    gpib_bus_ctrl #(.IFC_CYCLES(20)) dut (
        .clk(clk), .rst(rst), .ce(ce), .module_init_in(init), .command_data_out_reg(cdo),
        .out_wr(out_wr), .out_last(out_last), .out_ready(out_ready), .data_in_reg_q(din),
        .in_valid_q(in_valid), .in_is_cmd_q(in_cmd), .in_end_q(in_end), .in_rd(in_rd),
        .dma_mode(dma_mode), .dma_request_out(dma_req), .dma_grant_in_n(grant_n),
        .listen_en(listen_en), .talk_en(talk_en), .sys_ctrl_en(sys_ctrl_en),
        .take_control(take_control), .go_standby(go_standby), .pass_control(pass_control),
        .send_ifc(send_ifc), .ren_set(ren_set), .rsv(rsv), .par_poll(par_poll),
        .pp_resp_en(pp_resp_en), .pp_resp(pp_resp), .remote_q(remote), .cic(cic),
        .active_ctrl(active_ctrl), .ifc_busy(), .ifc_seen(ifc_seen), .srq_seen(srq_seen),
        .dio_i(dio_w), .dio_o(), .dio_oe_n(dio_oe_n), .dav_i(dav_w), .dav_o(),
        .dav_oe_n(dav_oe_n), .nrfd_i(nrfd_w), .nrfd_o(), .nrfd_oe_n(nrfd_oe_n),
        .ndac_i(ndac_w), .ndac_o(), .ndac_oe_n(ndac_oe_n), .atn_i(atn_w), .atn_o(),
        .atn_oe_n(atn_oe_n), .ifc_i(ifc_oe_n & ~x_ifc), .ifc_o(), .ifc_oe_n(ifc_oe_n),
        .ren_i(ren_oe_n & ~x_ren), .ren_o(), .ren_oe_n(ren_oe_n),
        .srq_i(srq_oe_n & ~x_srq), .srq_o(), .srq_oe_n(srq_oe_n), .eoi_i(eoi_w),
        .eoi_o(), .eoi_oe_n(eoi_oe_n)
    );
    far_instrument peer (
        .clk(clk), .dav_w(dav_w), .nrfd_w(nrfd_w), .ndac_w(ndac_w), .dio_w(dio_w),
        .eoi_w(eoi_w), .listen(peer_listen), .lag(peer_lag), .nrfd_low(p_nrfd),
        .ndac_low(p_ndac), .dav_low(p_dav), .dio_low(p_dio), .eoi_low(p_eoi)
    );
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask
    task automatic check(input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_out();
        while (out_ready !== 1'b1) tick();
        check(out_ready, 1'b1);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset();
        check({dav_oe_n, nrfd_oe_n, ndac_oe_n, atn_oe_n}, 4'hf);
        check({ifc_oe_n, ren_oe_n, srq_oe_n, eoi_oe_n}, 4'hf);
        check({dio_oe_n, out_ready, cic}, {8'hff, 2'h2});
        $display("test reset done");
    endtask
    task automatic t_talk();
        int i;
        logic [7:0] b;
        talk_en = 1;
        peer_listen = 1;
        peer_lag = 4'h3;
        for (i = 0; i < 2; i++) begin
            b = (i == 0) ? 8'ha5 : 8'h5a;
            cdo = b;
            out_last = (i == 0);
            pulse(out_wr);
            check(out_ready, 1'b0);
            wait_out();
            check(peer.rx_byte, b);
            check(peer.rx_end, i == 0);
        end
        talk_en = 0;
        peer_listen = 0;
        $display("test talk done");
    endtask
    task automatic t_listen();
        listen_en = 1;
        peer.send(8'h3c, 1'b0);
        check({din, in_valid, in_cmd, in_end}, {8'h3c, 3'h4});
        fork
            peer.send(8'hc3, 1'b1);
        join_none
        repeat (12) tick();
        check({dav_w, nrfd_oe_n}, 2'h2);
        pulse(in_rd);
        wait fork;
        check({din, in_valid, in_end}, {8'hc3, 2'h3});
        pulse(in_rd);
        listen_en = 0;
        x_atn = 1;
        tick();
        peer.send(8'h14, 1'b0);
        check({din, in_cmd}, {8'h14, 1'h1});
        pulse(in_rd);
        x_ren = 1;
        listen_en = 1;
        repeat (3) tick();
        check(remote, 1'b1);
        x_ren = 0;
        repeat (2) tick();
        check(remote, 1'b0);
        x_atn = 0;
        $display("test listen done");
    endtask
    task automatic t_dma();
        dma_mode = 1;
        tick();
        peer.send(8'h69, 1'b0);
        check({dma_req, din}, {1'h1, 8'h69});
        grant_n = 0;
        tick();
        grant_n = 1;
        check({dma_req, in_valid}, 2'h0);
        listen_en = 0;
        talk_en = 1;
        peer_listen = 1;
        peer_lag = 4'h0;
        cdo = 8'h96;
        grant_n = 0;
        tick();
        grant_n = 1;
        check({dma_req, out_ready}, 2'h0);
        wait_out();
        check(peer.rx_byte, 8'h96);
        dma_mode = 0;
        talk_en = 0;
        peer_listen = 0;
        $display("test dma done");
    endtask
    task automatic t_ctrl();
        int n;
        sys_ctrl_en = 1;
        pulse(send_ifc);
        n = 0;
        while (ifc_oe_n !== 1'b0 && n < 3) begin
            tick();
            n++;
        end
        n = 0;
        while (ifc_oe_n === 1'b0 && n < 100) begin
            tick();
            n++;
        end
        check(n, 32'h14);
        check({cic, active_ctrl, atn_oe_n}, 3'h6);
        ren_set = 1;
        repeat (2) tick();
        check(ren_oe_n, 1'b0);
        pulse(pass_control);
        tick();
        check({cic, ren_oe_n, atn_oe_n}, 3'h1);
        pulse(take_control);
        tick();
        check({cic, active_ctrl}, 2'h3);
        pulse(go_standby);
        tick();
        check({cic, active_ctrl, atn_oe_n}, 3'h5);
        pulse(take_control);
        par_poll = 1;
        repeat (2) tick();
        check({atn_oe_n, eoi_oe_n}, 2'h0);
        par_poll = 0;
        sys_ctrl_en = 0;
        repeat (2) tick();
        check(ren_oe_n, 1'b1);
        ren_set = 0;
        pulse(init);
        tick();
        check({cic, atn_oe_n, ifc_oe_n}, 3'h3);
        $display("test control done");
    endtask
    task automatic t_poll_srq();
        rsv = 1;
        repeat (2) tick();
        check({srq_oe_n, srq_seen}, 2'h1);
        rsv = 0;
        x_ifc = 1;
        tick();
        check(ifc_seen, 1'b1);
        x_ifc = 0;
        pp_resp = 8'h04;
        pp_resp_en = 1;
        x_atn = 1;
        x_eoi = 1;
        repeat (2) tick();
        check(dio_oe_n, 8'hfb);
        x_atn = 0;
        x_eoi = 0;
        pp_resp_en = 0;
        $display("test poll done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 0;
        t_reset();
        t_talk();
        t_listen();
        t_dma();
        t_ctrl();
        t_poll_srq();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule // ieee488_bus_handshake_control_test
